// >>> hscf_dev_model.sv
// Behavioural card module model answering the host on the serial link
`timescale 1ns/1ps
`default_nettype none
module hscf_dev_model #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic rx,
    output logic tx,
    input wire logic [1:0] mode
);
    logic [7:0] b [0:6];
    logic [7:0] v;
    logic [7:0] x;
    logic [7:0] st;
    logic [4:0] sp;
    logic nak;
    int n;

    // Samples mid-bit, lowest bit first
    task automatic get(output logic [7:0] d);
        while (rx !== 1'b0)
            @(posedge clk);
        repeat (DIV / 2) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (DIV) @(posedge clk);
            if (i < 8)
                d[i] = rx;
        end
    endtask

    task automatic put(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            tx <= f[i];
            repeat (DIV) @(posedge clk);
        end
    endtask

    // Known flag, command length, response length
    function automatic logic [4:0] spec(input logic [7:0] c);
        case (c)
            8'h41, 8'h54, 8'h48: spec = 5'h10;
            8'h49: spec = 5'h11;
            8'h53: spec = 5'h15;
            8'h52: spec = 5'h16;
            8'h57: spec = 5'h1C;
            8'h50: spec = 5'h18;
            default: spec = 5'h00;
        endcase
    endfunction

    task automatic serve();
        for (n = 0; n < 3; n++)
            get(b[n]);
        for (n = 3; n < 4 + b[2][1:0]; n++)
            get(b[n]);
        get(v);
        x = 8'h00;
        for (int i = 0; i < n; i++)
            x ^= b[i];
        sp = spec(b[1]);
        st = (x != 8'h00) ? 8'h03 : !sp[4] ? 8'h01 : (sp[3:2] != b[2][1:0]) ? 8'h02 : 8'h00;
        v = b[1];
        b[1] = st;
        b[2] = (st == 8'h00) ? {6'h00, sp[1:0]} : 8'h00;
        b[3] = v;
        b[4] = v + 8'h01;
        // Mode 2 spoils the checksum on purpose
        x = (mode == 2'h2) ? 8'hFF : 8'h00;
        for (int i = 0; i < 3 + b[2]; i++)
            x ^= b[i];
        put(hscf_pkg::CH_STX);
        get(v);
        if (v == hscf_pkg::CH_ACK)
        begin
            for (int i = 0; i < 3 + b[2]; i++)
                put(b[i]);
            put(x);
            put(hscf_pkg::CH_ETX);
        end
    endtask

    initial
    begin
        tx = 1'b1;
        nak = 1'b0;
        forever
        begin
            get(v);
            if (v == hscf_pkg::CH_STX && mode != 2'h1)
            begin
                nak = (mode == 2'h3) && !nak;
                put(nak ? hscf_pkg::CH_NAK : hscf_pkg::CH_ACK);
                if (!nak)
                    serve();
            end
        end
    end
endmodule
`default_nettype wire

// >>> hscf_host.sv
// Host controller: frames commands to the module and collects its responses
`timescale 1ns/1ps
`default_nettype none
module hscf_host #(
    parameter int BAUD_DIV_P = hscf_pkg::BAUD_DIV,
    parameter int T_HS_P = hscf_pkg::T_HS_CYC,
    parameter int T_BLK_P = hscf_pkg::T_BLK_CYC,
    parameter int T_GAP_P = hscf_pkg::T_GAP_CYC,
    parameter int T_RES_P = hscf_pkg::T_RES_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic rxd,
    output logic txd,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire hscf_pkg::hscf_cmd_s cmd,
    output logic resp_valid,
    input wire logic resp_ready,
    output var hscf_pkg::hscf_resp_s resp,
    output logic busy
);
    localparam int TW = hscf_pkg::TMR_W;
    localparam int BW = hscf_pkg::BAUD_W;
    localparam logic [BW-1:0] DIVM1_L = BW'(BAUD_DIV_P - 1);
    localparam logic [BW-1:0] HALF_L = BW'(BAUD_DIV_P / 2);
    localparam logic [TW-1:0] HS_L = TW'(T_HS_P);
    localparam logic [TW-1:0] BLK_L = TW'(T_BLK_P);
    localparam logic [TW-1:0] GAP_L = TW'(T_GAP_P);
    localparam logic [TW-1:0] RES_L = TW'(T_RES_P);

    hscf_pkg::hscf_state_e state_r, state_nxt;
    hscf_pkg::hscf_cmd_s cmd_r;
    hscf_pkg::hscf_resp_s rs_r, out_r, spare_r;
    logic [TW-1:0] tmr_r, lim;
    logic [2:0] idx_r, pay_end, etx_pos, rpe;
    logic [1:0] retry_r, pay_idx;
    logic [7:0] seq_r, xor_r, rxor_r, blk_byte, tx_val, exp_chk;
    logic err_r, tx_go, tmr_hit, tmr_clr, last_try, fin_ok, rx_fin;
    logic out_v_r, spare_v_r, push, pop, cmd_ready_r, busy_r;
    logic rx_s1, rx_s2, rx_s3, rx_lvl_r, rx_busy_r, rx_stb_r;
    logic [BW-1:0] rx_cnt_r, tx_cnt_r;
    logic [3:0] rx_bit_r, tx_bit_r;
    logic [7:0] rx_sh_r, rx_dat_r;
    logic tx_busy_r, txd_r;
    logic [8:0] tx_sh_r;
    logic rx_ack, rx_nak, rx_stx;

    assign txd = txd_r;
    assign cmd_ready = cmd_ready_r;
    assign busy = busy_r;
    assign resp_valid = out_v_r;
    assign resp = out_r;

    // Rx pin: three stages, level accepted once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_lvl_r <= 1'b1;
        end
        else
        begin
            rx_s1 <= rxd;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3)
                rx_lvl_r <= rx_s3;
        end
    end

    // Receiver samples mid-bit; a start that is gone at mid-bit is a glitch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_busy_r <= 1'b0;
            rx_stb_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_dat_r <= 8'h00;
        end
        else
        begin
            rx_stb_r <= 1'b0;
            if (!rx_busy_r)
            begin
                if (!rx_lvl_r)
                begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r <= HALF_L;
                    rx_bit_r <= 4'h0;
                end
            end
            else if (rx_cnt_r != '0)
                rx_cnt_r <= rx_cnt_r - 1'b1;
            else
            begin
                rx_cnt_r <= DIVM1_L;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_lvl_r)
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == hscf_pkg::LAST_BIT)
                begin
                    rx_busy_r <= 1'b0;
                    rx_stb_r <= rx_lvl_r;
                    rx_dat_r <= rx_sh_r;
                end
                else if (rx_bit_r != 4'h0)
                    rx_sh_r <= {rx_lvl_r, rx_sh_r[7:1]};
            end
        end
    end

    // Transmitter: start bit on load, then data lowest bit first, then stop
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_busy_r <= 1'b0;
            txd_r <= 1'b1;
            tx_cnt_r <= '0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 9'h1FF;
        end
        else if (!tx_busy_r)
        begin
            if (tx_go)
            begin
                tx_busy_r <= 1'b1;
                txd_r <= 1'b0;
                tx_cnt_r <= DIVM1_L;
                tx_bit_r <= 4'h0;
                tx_sh_r <= {1'b1, tx_val};
            end
        end
        else if (tx_cnt_r != '0)
            tx_cnt_r <= tx_cnt_r - 1'b1;
        else if (tx_bit_r == hscf_pkg::LAST_BIT)
            tx_busy_r <= 1'b0;
        else
        begin
            txd_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[8:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_cnt_r <= DIVM1_L;
        end
    end

    a_start_bit: assert property (@(posedge clk) disable iff (!arst_n)
        tx_go && !tx_busy_r |=> !txd_r && tx_busy_r)
        else $error("start bit not driven on load");
    a_stop_level: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(tx_busy_r) |-> txd_r && $past(txd_r))
        else $error("frame ended without stop level");

    assign rx_ack = rx_stb_r && rx_dat_r == hscf_pkg::CH_ACK;
    assign rx_nak = rx_stb_r && rx_dat_r == hscf_pkg::CH_NAK;
    assign rx_stx = rx_stb_r && rx_dat_r == hscf_pkg::CH_STX;

    // Block layout, checksum closes the block and ETX ends it
    assign pay_end = hscf_pkg::POS_PAY + {1'b0, cmd_r.len};
    assign etx_pos = pay_end + 3'h1;
    assign pay_idx = 2'(idx_r - hscf_pkg::POS_PAY);
    assign blk_byte = (idx_r == hscf_pkg::POS_SEQ) ? seq_r :
        (idx_r == hscf_pkg::POS_CODE) ? cmd_r.code :
        (idx_r == hscf_pkg::POS_LEN) ? {6'h00, cmd_r.len} :
        (idx_r < pay_end) ? cmd_r.data[pay_idx] :
        (idx_r == pay_end) ? xor_r : hscf_pkg::CH_ETX;
    assign exp_chk = seq_r ^ cmd_r.code ^ {6'h00, cmd_r.len} ^
        ((cmd_r.len > 2'h0) ? cmd_r.data[0] : 8'h00) ^
        ((cmd_r.len > 2'h1) ? cmd_r.data[1] : 8'h00) ^
        ((cmd_r.len > 2'h2) ? cmd_r.data[2] : 8'h00);

    // One timer serves every wait; its limit follows the state
    assign lim = (state_r == hscf_pkg::S_WACK) ? HS_L :
        (state_r == hscf_pkg::S_WRES) ? RES_L :
        (state_r == hscf_pkg::S_RBLK && idx_r == 3'h0) ? BLK_L : GAP_L;
    assign tmr_hit = tmr_r >= lim;
    // Held while our own byte is on the wire, so waits start after it
    assign tmr_clr = state_nxt != state_r || tx_busy_r ||
        state_r == hscf_pkg::S_IDLE || (state_r == hscf_pkg::S_RBLK && rx_stb_r);
    assign last_try = retry_r == hscf_pkg::RETRY_MAX;

    assign rpe = hscf_pkg::POS_PAY + {1'b0, rs_r.len};
    assign rx_fin = rx_stb_r && state_r == hscf_pkg::S_RBLK && idx_r == rpe + 3'h1;
    assign fin_ok = rx_dat_r == hscf_pkg::CH_ETX && rxor_r == 8'h00 && !err_r &&
        rs_r.seq == seq_r && (rs_r.status == 8'h00 || rs_r.len == 2'h0);

    always_comb
    begin
        state_nxt = state_r;
        tx_go = 1'b0;
        tx_val = blk_byte;
        unique case (state_r)
            hscf_pkg::S_IDLE:
                if (cmd_valid)
                    state_nxt = hscf_pkg::S_STX;
            hscf_pkg::S_STX:
                if (!tx_busy_r)
                begin
                    tx_go = 1'b1;
                    tx_val = hscf_pkg::CH_STX;
                    state_nxt = hscf_pkg::S_WACK;
                end
            hscf_pkg::S_WACK:
                if (rx_ack)
                    state_nxt = hscf_pkg::S_BLK;
                else if (rx_nak || tmr_hit)
                    state_nxt = last_try ? hscf_pkg::S_PUSH : hscf_pkg::S_STX;
            hscf_pkg::S_BLK:
                if (rx_stb_r)
                    state_nxt = hscf_pkg::S_BACK;
                else if (!tx_busy_r)
                begin
                    // Back to back bytes keep well inside the gap limit
                    tx_go = 1'b1;
                    if (idx_r == etx_pos)
                        state_nxt = hscf_pkg::S_WRES;
                end
            hscf_pkg::S_BACK:
                if (tmr_hit)
                    state_nxt = last_try ? hscf_pkg::S_PUSH : hscf_pkg::S_STX;
            hscf_pkg::S_WRES:
                if (rx_stx)
                    state_nxt = hscf_pkg::S_RACK;
                else if (tmr_hit)
                    state_nxt = hscf_pkg::S_PUSH;
            hscf_pkg::S_RACK:
                if (!tx_busy_r)
                begin
                    tx_go = 1'b1;
                    tx_val = hscf_pkg::CH_ACK;
                    state_nxt = hscf_pkg::S_RBLK;
                end
            hscf_pkg::S_RBLK:
                if (rx_fin || tmr_hit)
                    state_nxt = hscf_pkg::S_PUSH;
            hscf_pkg::S_PUSH:
                if (!spare_v_r)
                    state_nxt = hscf_pkg::S_IDLE;
            default:
                state_nxt = hscf_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= hscf_pkg::S_IDLE;
            tmr_r <= '0;
            cmd_ready_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r <= tmr_clr ? '0 : tmr_r + 1'b1;
            cmd_ready_r <= state_nxt == hscf_pkg::S_IDLE;
            busy_r <= state_nxt != hscf_pkg::S_IDLE;
        end
    end

    // Command side: retries, block index, running checksum, sequence
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_r <= '0;
            retry_r <= 2'h0;
            idx_r <= 3'h0;
            xor_r <= 8'h00;
            seq_r <= hscf_pkg::SEQ_RST;
        end
        else
        begin
            if (state_r == hscf_pkg::S_IDLE && cmd_valid)
            begin
                cmd_r <= cmd;
                retry_r <= 2'h0;
            end
            if (state_r != hscf_pkg::S_STX && state_nxt == hscf_pkg::S_STX && state_r != hscf_pkg::S_IDLE)
                retry_r <= retry_r + 2'h1;
            if ((state_nxt == hscf_pkg::S_BLK && state_r != hscf_pkg::S_BLK) ||
                (state_nxt == hscf_pkg::S_RBLK && state_r != hscf_pkg::S_RBLK))
            begin
                idx_r <= 3'h0;
                xor_r <= 8'h00;
            end
            else if ((state_r == hscf_pkg::S_BLK && tx_go) || (state_r == hscf_pkg::S_RBLK && rx_stb_r))
                idx_r <= idx_r + 3'h1;
            if (state_r == hscf_pkg::S_BLK && tx_go && idx_r < pay_end)
                xor_r <= xor_r ^ tx_val;
            if (push && rs_r.link == hscf_pkg::LINK_OK)
                seq_r <= seq_r + 8'h01;
        end
    end

    // Response side: fields by position, checksum over all bytes before ETX to zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rs_r <= '0;
            rxor_r <= 8'h00;
            err_r <= 1'b0;
        end
        else if (state_r == hscf_pkg::S_RACK)
        begin
            rxor_r <= 8'h00;
            err_r <= 1'b0;
            rs_r <= '0;
        end
        else if (state_r == hscf_pkg::S_RBLK && rx_stb_r && !rx_fin)
        begin
            rxor_r <= rxor_r ^ rx_dat_r;
            if (idx_r == hscf_pkg::POS_SEQ)
                rs_r.seq <= rx_dat_r;
            else if (idx_r == hscf_pkg::POS_CODE)
                rs_r.status <= rx_dat_r;
            else if (idx_r == hscf_pkg::POS_LEN)
            begin
                // Oversized length is flagged and read as zero to keep framing
                err_r <= rx_dat_r > hscf_pkg::RSP_LEN_MAX;
                rs_r.len <= (rx_dat_r > hscf_pkg::RSP_LEN_MAX) ? 2'h0 : rx_dat_r[1:0];
            end
            else if (idx_r < rpe)
                rs_r.data[1'(idx_r - hscf_pkg::POS_PAY)] <= rx_dat_r;
        end
        else if (state_nxt == hscf_pkg::S_PUSH && state_r != hscf_pkg::S_PUSH)
            rs_r.link <= (state_r != hscf_pkg::S_RBLK) ? hscf_pkg::LINK_NOANS :
                (rx_fin && fin_ok) ? hscf_pkg::LINK_OK : hscf_pkg::LINK_BAD;
    end

    // Two-entry buffer; a full buffer holds the machine in its push state
    assign push = state_r == hscf_pkg::S_PUSH && !spare_v_r;
    assign pop = out_v_r && resp_ready;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_v_r <= 1'b0;
            spare_v_r <= 1'b0;
            out_r <= '0;
            spare_r <= '0;
        end
        else if (pop)
        begin
            if (spare_v_r)
            begin
                out_r <= spare_r;
                spare_v_r <= 1'b0;
            end
            else if (push)
                out_r <= rs_r;
            else
                out_v_r <= 1'b0;
        end
        else if (push)
        begin
            if (!out_v_r)
            begin
                out_r <= rs_r;
                out_v_r <= 1'b1;
            end
            else
            begin
                spare_r <= rs_r;
                spare_v_r <= 1'b1;
            end
        end
    end

    a_stx_opens: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state_r == hscf_pkg::S_WACK) |-> $past(tx_val) == hscf_pkg::CH_STX && tx_busy_r)
        else $error("handshake not opened with STX");
    a_ack_wait: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_WACK |-> tmr_r <= HS_L)
        else $error("handshake wait overran its limit");
    a_blk_prompt: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state_r == hscf_pkg::S_BLK) && !tx_busy_r |-> ##[1:2] tx_busy_r)
        else $error("command block not started promptly");
    a_len_field: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_BLK && tx_go && idx_r == hscf_pkg::POS_LEN |-> tx_val <= 8'h03)
        else $error("length byte out of range");
    a_chk_byte: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_BLK && tx_go && idx_r == pay_end |-> tx_val == exp_chk)
        else $error("checksum byte wrong");
    a_sync_abort: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_BLK && rx_stb_r |=> state_r == hscf_pkg::S_BACK ##1 !tx_go)
        else $error("byte during block did not abort");
    a_etx_last: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_BLK && state_nxt == hscf_pkg::S_WRES |-> tx_go && tx_val == hscf_pkg::CH_ETX)
        else $error("block not closed by ETX");
    a_ack_reply: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_WRES && rx_stx |=> state_r == hscf_pkg::S_RACK)
        else $error("module STX not answered with ACK");
    // The wait for a free line is bounded by the transmitter's own frame
    a_ack_load: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == hscf_pkg::S_RACK |-> tx_busy_r || (tx_go && tx_val == hscf_pkg::CH_ACK))
        else $error("ACK not loaded once the line is free");
    a_seq_step: assert property (@(posedge clk) disable iff (!arst_n)
        push && rs_r.link == hscf_pkg::LINK_OK |=> seq_r == $past(seq_r) + 8'h01)
        else $error("sequence number not stepped");
endmodule
`default_nettype wire

// >>> hscf_host_test.sv
// Self-checking bench for the host serial command framer
`timescale 1ns/1ps
`default_nettype none
module hscf_host_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic line_dn;
    logic line_up;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    hscf_pkg::hscf_cmd_s cmd = '0;
    logic resp_valid;
    logic resp_ready = 1'b0;
    hscf_pkg::hscf_resp_s resp;
    logic busy;
    logic [1:0] mode = 2'h0;
    logic [7:0] seq = 8'h00;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    hscf_host #(.BAUD_DIV_P(16), .T_HS_P(2000), .T_BLK_P(3000), .T_GAP_P(1000), .T_RES_P(8000)) uut (
        .clk(clk), .arst_n(arst_n), .rxd(line_up), .txd(line_dn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp), .busy(busy));

    hscf_dev_model dev (.clk(clk), .rx(line_dn), .tx(line_up), .mode(mode));

    task automatic finish_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard sized well above the planned traffic
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 99000)
        begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic [7:0] c, input logic [1:0] l, input logic [23:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= {c, l, d};
        @(posedge clk);
        while (cmd_ready !== 1'b1)
            @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic pop(input logic [1:0] lk, input logic [7:0] st, input logic [1:0] ln, input logic [15:0] dt);
        logic [15:0] m;
        m = ~(16'hFFFF << {ln, 3'h0});
        @(posedge clk);
        while (resp_valid !== 1'b1)
            @(posedge clk);
        check(resp.link, lk);
        if (lk != 2'h1)
            check(resp.seq, seq);
        if (lk == 2'h0)
        begin
            check(resp.status, st);
            check(resp.len, ln);
            check(resp.data & m, dt & m);
            seq = seq + 8'h01;
        end
        resp_ready <= 1'b1;
        @(posedge clk);
        resp_ready <= 1'b0;
    endtask

    task automatic t_codes();
        logic [11:0] t [0:7] = '{12'h410, 12'h540, 12'h491, 12'h535, 12'h526, 12'h57C, 12'h508, 12'h480};
        for (int i = 0; i < 8; i++)
        begin
            send(t[i][11:4], t[i][3:2], 24'hC0FFEE);
            pop(2'h0, 8'h00, t[i][1:0], {t[i][11:4] + 8'h01, t[i][11:4]});
        end
    endtask

    task automatic t_errors();
        send(8'h41, 2'h1, 24'h000000);
        pop(2'h0, 8'h02, 2'h0, 16'h0000);
        send(8'h99, 2'h0, 24'h000000);
        pop(2'h0, 8'h01, 2'h0, 16'h0000);
    endtask

    task automatic t_link_faults();
        mode <= 2'h3;
        send(8'h52, 2'h1, 24'h000003);
        pop(2'h0, 8'h00, 2'h2, 16'h5352);
        mode <= 2'h1;
        send(8'h52, 2'h1, 24'h000003);
        pop(2'h1, 8'h00, 2'h0, 16'h0000);
        mode <= 2'h2;
        send(8'h52, 2'h1, 24'h000003);
        pop(2'h2, 8'h00, 2'h0, 16'h0000);
        mode <= 2'h0;
    endtask

    // Third result must wait while two sit unread
    task automatic t_buffer();
        send(8'h49, 2'h0, 24'h000000);
        send(8'h52, 2'h1, 24'h000007);
        send(8'h41, 2'h0, 24'h000000);
        repeat (6000) @(posedge clk);
        check({busy, cmd_ready, resp_valid}, 3'h5);
        pop(2'h0, 8'h00, 2'h1, 16'h0049);
        pop(2'h0, 8'h00, 2'h2, 16'h5352);
        pop(2'h0, 8'h00, 2'h0, 16'h0000);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        check({line_dn, cmd_ready, busy, resp_valid}, 4'h8);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        send(8'h52, 2'h1, 24'h000005);
        pop(2'h0, 8'h00, 2'h2, 16'h5352);
        t_codes();
        t_errors();
        t_link_faults();
        t_buffer();
        finish_test();
    end
endmodule
`default_nettype wire

// >>> hscf_pkg.sv
// Constants and types for the host serial command framer
// Notes on behaviour
// - Byte: start, eight data, stop, 9600 baud
// - Lowest byte and lowest bit go first
// - Fixed STX, ETX, ACK, NAK character codes
// - No answer in 20 ms: resend or fail
// - Host starts command block within 45 ms
// - Host gaps between command bytes below 15 ms
// - Byte heard while sending: stop, wait, restart
// - Host ends block with ETX, then waits
// - Module sends STX; host answers ACK
// - Block: sequence, code, length, payload, checksum
// - Sequence steps after success; module echoes it
// - Command code is one byte, eight operations
// - Command payload length is zero to three
// - Checksum is XOR of all preceding bytes
package hscf_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD = 9600;
    localparam int BAUD_DIV = CLK_HZ / BAUD;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int T_HS_MS = 20;
    localparam int T_BLK_MS = 45;
    localparam int T_GAP_MS = 15;
    localparam int T_RES_MS = 150;
    localparam int T_HS_CYC = T_HS_MS * CYC_PER_MS;
    localparam int T_BLK_CYC = T_BLK_MS * CYC_PER_MS;
    localparam int T_GAP_CYC = T_GAP_MS * CYC_PER_MS;
    localparam int T_RES_CYC = T_RES_MS * CYC_PER_MS;
    localparam int TMR_W = 25;
    localparam int BAUD_W = 14;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam logic [1:0] RETRY_MAX = 2'h3;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [2:0] POS_SEQ = 3'h0;
    localparam logic [2:0] POS_CODE = 3'h1;
    localparam logic [2:0] POS_LEN = 3'h2;
    localparam logic [2:0] POS_PAY = 3'h3;
    localparam logic [7:0] RSP_LEN_MAX = 8'h02;
    localparam logic [7:0] SEQ_RST = 8'h00;
    localparam logic [1:0] LINK_OK = 2'h0;
    localparam logic [1:0] LINK_NOANS = 2'h1;
    localparam logic [1:0] LINK_BAD = 2'h2;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_STX = 9'h002,
        S_WACK = 9'h004,
        S_BLK = 9'h008,
        S_BACK = 9'h010,
        S_WRES = 9'h020,
        S_RACK = 9'h040,
        S_RBLK = 9'h080,
        S_PUSH = 9'h100
    } hscf_state_e;
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] len;
        logic [2:0][7:0] data;
    } hscf_cmd_s;
    typedef struct packed {
        logic [1:0] link;
        logic [7:0] seq;
        logic [7:0] status;
        logic [1:0] len;
        logic [1:0][7:0] data;
    } hscf_resp_s;
endpackage
